/* File: rtl/ocpr_regs.sv */
// AHB-Lite register bank for overlay, pointer and blend plane setup.
// Assumes one master, word transfers, zero-wait answers from this slave.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ns
module ocpr_regs #(
  parameter int FIFO_W = 4
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Overlay flip events from the display pipe
  input wire logic flip_done_i,
  // Blend plane fifo empty count
  input wire logic [FIFO_W-1:0] blend_empty_i,
  // Decoded controls
  output logic ovl_src_host_o,
  output logic ovl_vshrink_o,
  output logic ovl_hshrink_o,
  output logic [11:0] vertical_ratio_o,
  output logic [11:0] horizontal_ratio_o,
  output logic pointer_overlay_show_o,
  output logic pointer_src_host_o,
  output logic blend_const_alpha_o,
  output logic [3:0] blend_alpha_o,
  output logic key_match_enable_o,
  output logic blend_plane_en_o,
  output logic [1:0] blend_format_o,
  output logic blend_fetch_req_o,
  output logic flip_pending_o
);
  initial begin
    if (FIFO_W < 4) $error("FIFO_W must be at least 4");
  end

  logic [31:0] ovl_addr_r, ovl_stride_r, ovl_last_r, ovl_tl_r, ovl_br_r;
  logic [31:0] ovl_scale_r, ovl_init_r, ovl_key_r;
  logic [31:0] pal_r [ocpr_pkg::PAL_WORDS];
  logic [31:0] ptr_addr_r, ptr_pos_r, ptr_col12_r, ptr_col3_r;
  logic [31:0] bld_ctrl_r, bld_addr_r;
  logic flip_r;
  logic wr_pend_r;
  logic [19:0] wr_ofs_r;
  logic [31:0] rd_nxt;
  logic take;
  logic [19:0] ofs;
  logic in_pal;
  logic [2:0] pal_idx;
  logic [3:0] lvl;
  logic [19:0] pal_rel;

  // Accept only word transfers; others are ignored but answered OKAY
  assign take = hsel_i && hready_i && htrans_i == ocpr_pkg::HTRANS_NONSEQ
    && hsize_i == ocpr_pkg::HSIZE_WORD;
  assign ofs = haddr_i[19:0];
  assign pal_rel = wr_ofs_r - ocpr_pkg::OFS_OVL_PAL;

  // Palette window covers eight consecutive words
  assign in_pal = wr_ofs_r >= ocpr_pkg::OFS_OVL_PAL
    && wr_ofs_r < ocpr_pkg::OFS_OVL_PAL + 20'h20;
  assign pal_idx = pal_rel[4:2];

  // Address phase latch for writes
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r <= 20'h00000;
    end else begin
      wr_pend_r <= take && hwrite_i;
      if (take) begin
        wr_ofs_r <= ofs;
      end
    end
  end

  // Data phase register writes, masked so reserved bits stay zero
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ovl_addr_r <= ocpr_pkg::RST_VAL;
      ovl_stride_r <= ocpr_pkg::RST_VAL;
      ovl_last_r <= ocpr_pkg::RST_VAL;
      ovl_tl_r <= ocpr_pkg::RST_VAL;
      ovl_br_r <= ocpr_pkg::RST_VAL;
      ovl_scale_r <= ocpr_pkg::RST_VAL;
      ovl_init_r <= ocpr_pkg::RST_VAL;
      ovl_key_r <= ocpr_pkg::RST_VAL;
      ptr_addr_r <= ocpr_pkg::RST_VAL;
      ptr_pos_r <= ocpr_pkg::RST_VAL;
      ptr_col12_r <= ocpr_pkg::RST_VAL;
      ptr_col3_r <= ocpr_pkg::RST_VAL;
      bld_ctrl_r <= ocpr_pkg::RST_VAL;
      bld_addr_r <= ocpr_pkg::RST_VAL;
      for (int i = 0; i < ocpr_pkg::PAL_WORDS; i++) begin
        pal_r[i] <= ocpr_pkg::RST_VAL;
      end
    end else if (wr_pend_r) begin
      unique case (wr_ofs_r)
        ocpr_pkg::OFS_OVL_ADDR:
          ovl_addr_r <= hwdata_i & ocpr_pkg::MSK_OVL_ADDR;
        ocpr_pkg::OFS_OVL_STRIDE:
          ovl_stride_r <= hwdata_i & ocpr_pkg::MSK_STRIDE;
        ocpr_pkg::OFS_OVL_LAST:
          ovl_last_r <= hwdata_i & ocpr_pkg::MSK_ADDR;
        ocpr_pkg::OFS_OVL_TL:
          ovl_tl_r <= hwdata_i & ocpr_pkg::MSK_LOC;
        ocpr_pkg::OFS_OVL_BR:
          ovl_br_r <= hwdata_i & ocpr_pkg::MSK_LOC;
        ocpr_pkg::OFS_OVL_SCALE:
          ovl_scale_r <= hwdata_i & ocpr_pkg::MSK_SCALE;
        ocpr_pkg::OFS_OVL_INIT:
          ovl_init_r <= hwdata_i & ocpr_pkg::MSK_INIT;
        ocpr_pkg::OFS_OVL_KEY:
          ovl_key_r <= hwdata_i & ocpr_pkg::MSK_FULL;
        ocpr_pkg::OFS_PTR_ADDR:
          ptr_addr_r <= hwdata_i & ocpr_pkg::MSK_PTR_ADDR;
        ocpr_pkg::OFS_PTR_POS:
          ptr_pos_r <= hwdata_i & ocpr_pkg::MSK_PTR_POS;
        ocpr_pkg::OFS_PTR_COL12:
          ptr_col12_r <= hwdata_i & ocpr_pkg::MSK_FULL;
        ocpr_pkg::OFS_PTR_COL3:
          ptr_col3_r <= hwdata_i & ocpr_pkg::MSK_LOW16;
        ocpr_pkg::OFS_BLD_CTRL:
          bld_ctrl_r <= hwdata_i & ocpr_pkg::MSK_BLD_CTRL;
        ocpr_pkg::OFS_BLD_ADDR:
          bld_addr_r <= hwdata_i & ocpr_pkg::MSK_ADDR;
        default: begin
          if (in_pal) begin
            pal_r[pal_idx] <= hwdata_i;
          end
        end
      endcase
    end
  end

  // Flip pending: set by a write to the overlay address, cleared by the
  // pipe; a new write in the same cycle as the flip keeps it pending
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flip_r <= 1'b0;
    end else if (wr_pend_r && wr_ofs_r == ocpr_pkg::OFS_OVL_ADDR) begin
      flip_r <= 1'b1;
    end else if (flip_done_i) begin
      flip_r <= 1'b0;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (ofs)
      ocpr_pkg::OFS_OVL_ADDR: begin
        rd_nxt = ovl_addr_r;
        rd_nxt[ocpr_pkg::BIT_FLIP] = flip_r;
      end
      ocpr_pkg::OFS_OVL_STRIDE: rd_nxt = ovl_stride_r;
      ocpr_pkg::OFS_OVL_LAST: rd_nxt = ovl_last_r;
      ocpr_pkg::OFS_OVL_TL: rd_nxt = ovl_tl_r;
      ocpr_pkg::OFS_OVL_BR: rd_nxt = ovl_br_r;
      ocpr_pkg::OFS_OVL_SCALE: rd_nxt = ovl_scale_r;
      ocpr_pkg::OFS_OVL_INIT: rd_nxt = ovl_init_r;
      ocpr_pkg::OFS_OVL_KEY: rd_nxt = ovl_key_r;
      ocpr_pkg::OFS_PTR_ADDR: rd_nxt = ptr_addr_r;
      ocpr_pkg::OFS_PTR_POS: rd_nxt = ptr_pos_r;
      ocpr_pkg::OFS_PTR_COL12: rd_nxt = ptr_col12_r;
      ocpr_pkg::OFS_PTR_COL3: rd_nxt = ptr_col3_r;
      ocpr_pkg::OFS_BLD_CTRL: rd_nxt = bld_ctrl_r;
      ocpr_pkg::OFS_BLD_ADDR: rd_nxt = bld_addr_r;
      default: begin
        if (ofs >= ocpr_pkg::OFS_OVL_PAL
            && ofs < ocpr_pkg::OFS_OVL_PAL + 20'h20) begin
          rd_nxt = pal_r[ofs[4:2] - ocpr_pkg::OFS_OVL_PAL[4:2]];
        end
      end
    endcase
  end

  // Read data registered at the address phase, stands in the data phase
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      if (take && !hwrite_i) begin
        hrdata_o <= rd_nxt;
      end
    end
  end

  // Fetch threshold decode for the blend plane fifo
  always_comb begin
    unique case (bld_ctrl_r[17:16])
      2'h0: lvl = ocpr_pkg::LVL0;
      2'h1: lvl = ocpr_pkg::LVL1;
      2'h2: lvl = ocpr_pkg::LVL2;
      2'h3: lvl = ocpr_pkg::LVL3;
    endcase
  end

  // Decoded controls, all registered
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ovl_src_host_o <= 1'b0;
      ovl_vshrink_o <= 1'b0;
      ovl_hshrink_o <= 1'b0;
      vertical_ratio_o <= 12'h000;
      horizontal_ratio_o <= 12'h000;
      pointer_overlay_show_o <= 1'b0;
      pointer_src_host_o <= 1'b0;
      blend_const_alpha_o <= 1'b0;
      blend_alpha_o <= 4'h0;
      key_match_enable_o <= 1'b0;
      blend_plane_en_o <= 1'b0;
      blend_format_o <= 2'h0;
      blend_fetch_req_o <= 1'b0;
      flip_pending_o <= 1'b0;
    end else begin
      ovl_src_host_o <= ovl_addr_r[ocpr_pkg::BIT_SRC];
      ovl_vshrink_o <= ovl_scale_r[ocpr_pkg::BIT_VSHRINK];
      ovl_hshrink_o <= ovl_scale_r[ocpr_pkg::BIT_HSHRINK];
      vertical_ratio_o <= ovl_scale_r[27:16];
      horizontal_ratio_o <= ovl_scale_r[11:0];
      pointer_overlay_show_o <= ptr_addr_r[ocpr_pkg::BIT_PTR_EN];
      pointer_src_host_o <= ptr_addr_r[ocpr_pkg::BIT_SRC];
      blend_const_alpha_o <= bld_ctrl_r[ocpr_pkg::BIT_ASEL];
      blend_alpha_o <= bld_ctrl_r[27:24];
      key_match_enable_o <= bld_ctrl_r[ocpr_pkg::BIT_KEY_EN];
      blend_plane_en_o <= bld_ctrl_r[ocpr_pkg::BIT_PLANE_EN];
      blend_format_o <= bld_ctrl_r[1:0];
      blend_fetch_req_o <= bld_ctrl_r[ocpr_pkg::BIT_PLANE_EN]
        && blend_empty_i >= FIFO_W'(lvl);
      flip_pending_o <= flip_r;
    end
  end

  // Checks
  flip_set_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    wr_pend_r && wr_ofs_r == ocpr_pkg::OFS_OVL_ADDR |=> flip_r)
    else $error("flip pending not set after address write");
  flip_clear_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    flip_done_i && !wr_pend_r |=> !flip_r ##1 !flip_pending_o)
    else $error("flip pending not cleared");
  addr_low_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    ovl_addr_r[3:0] == 4'h0 && ptr_addr_r[3:0] == 4'h0)
    else $error("address low nibble not zero");
  resv_zero_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    ptr_col3_r[31:16] == 16'h0000 && bld_ctrl_r[15:8] == 8'h00)
    else $error("reserved bits not zero");
  ptr_show_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    wr_pend_r && wr_ofs_r == ocpr_pkg::OFS_PTR_ADDR
    |=> ##1 pointer_overlay_show_o == $past(hwdata_i[31], 2))
    else $error("pointer show does not follow enable bit");
  fetch_req_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    bld_ctrl_r[17:16] == 2'h3 && bld_ctrl_r[2] && blend_empty_i < 4'hb
    |=> !blend_fetch_req_o)
    else $error("fetch request below threshold");
  ratio_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    wr_pend_r && wr_ofs_r == ocpr_pkg::OFS_OVL_SCALE
    |=> ##1 horizontal_ratio_o == $past(hwdata_i[11:0], 2))
    else $error("horizontal ratio not taken");
  ready_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    hreadyout_o && !hresp_o)
    else $error("slave not ready or error response");

  // Reserved bits stay clear whatever software writes
  loc_resv_a: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (ovl_tl_r & ~ocpr_pkg::MSK_LOC) == 32'h0000_0000
    && (ovl_br_r & ~ocpr_pkg::MSK_LOC) == 32'h0000_0000)
    else $error("location reserved bits set");
  scale_resv_a: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (ovl_scale_r & ~ocpr_pkg::MSK_SCALE) == 32'h0000_0000
    && (ovl_init_r & ~ocpr_pkg::MSK_INIT) == 32'h0000_0000)
    else $error("scale reserved bits set");
  stride_resv_a: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (ovl_stride_r & ~ocpr_pkg::MSK_STRIDE) == 32'h0000_0000
    && (ovl_last_r & ~ocpr_pkg::MSK_ADDR) == 32'h0000_0000)
    else $error("stride reserved bits set");
  ptr_resv_a: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    (ptr_pos_r & ~ocpr_pkg::MSK_PTR_POS) == 32'h0000_0000
    && (bld_addr_r & ~ocpr_pkg::MSK_ADDR) == 32'h0000_0000)
    else $error("pointer reserved bits set");
  // Key enable output follows the control write two edges later
  key_out_a: assert property (
    @(posedge sys_clk_i) disable iff (!arst_n_i)
    wr_pend_r && wr_ofs_r == ocpr_pkg::OFS_BLD_CTRL
    |=> ##1 key_match_enable_o == $past(hwdata_i[3], 2))
    else $error("key enable does not follow control bit");
endmodule

/* File: shared/ocpr_pkg.sv */
// Constants for the overlay, cursor and blend plane register bank.
// Assumes an AHB-Lite slave that decodes the word offsets below.
// Contract
// - Overlay address bit 31 shows flip pending
// - Address bit 27 picks local or host memory
// - Overlay address in 25:4, low nibble zero
// - Stride holds window width and pitch
// - Last address register with own source bit
// - Top-left holds top line, left pixel
// - Bottom-right holds bottom line, right pixel
// - Scale bits 31/15 pick shrink or expand
// - Twelve-bit ratios in 27:16 and 11:0
// - Initial scale holds starting phases
// - Colour key value with per-bit mask
// - Eight palette words hold sixteen 565 entries
// - Pointer shown only when bit 31 set
// - Pointer address in 25:4, low nibble zero
// - Pointer position vertical 26:16, horizontal 10:0
// - Pointer bits 27/11 flag top/left overhang
// - Pointer colours one, two, three in 565
// - Bit 28 picks per-pixel or constant alpha
// - Bits 17:16 pick fetch request empty level
// - Bits 7:4 give panning start pixel
// - Bit 3 key enable, bit 2 plane enable
// - Bits 1:0 select blend plane format
package ocpr_pkg;
  localparam logic [19:0] OFS_OVL_ADDR = 20'h80084;
  localparam logic [19:0] OFS_OVL_STRIDE = 20'h80088;
  localparam logic [19:0] OFS_OVL_LAST = 20'h8008c;
  localparam logic [19:0] OFS_OVL_TL = 20'h80090;
  localparam logic [19:0] OFS_OVL_BR = 20'h80094;
  localparam logic [19:0] OFS_OVL_SCALE = 20'h80098;
  localparam logic [19:0] OFS_OVL_INIT = 20'h8009c;
  localparam logic [19:0] OFS_OVL_KEY = 20'h800a0;
  localparam logic [19:0] OFS_OVL_PAL = 20'h800a4;
  localparam logic [19:0] OFS_PTR_ADDR = 20'h800f0;
  localparam logic [19:0] OFS_PTR_POS = 20'h800f4;
  localparam logic [19:0] OFS_PTR_COL12 = 20'h800f8;
  localparam logic [19:0] OFS_PTR_COL3 = 20'h800fc;
  localparam logic [19:0] OFS_BLD_CTRL = 20'h80100;
  localparam logic [19:0] OFS_BLD_ADDR = 20'h80104;
  localparam int PAL_WORDS = 8;
  // Writable bit masks; all other bits read zero, except overlay address bit 31, which reads flip pending
  localparam logic [31:0] MSK_OVL_ADDR = 32'h0bff_fff0;
  localparam logic [31:0] MSK_ADDR = 32'h0bff_fff0;
  localparam logic [31:0] MSK_PTR_ADDR = 32'h8bff_fff0;
  localparam logic [31:0] MSK_STRIDE = 32'h3ff0_3ff0;
  localparam logic [31:0] MSK_LOC = 32'h07ff_07ff;
  localparam logic [31:0] MSK_PTR_POS = 32'h0fff_0fff;
  localparam logic [31:0] MSK_SCALE = 32'h8fff_8fff;
  localparam logic [31:0] MSK_INIT = 32'h0fff_0fff;
  localparam logic [31:0] MSK_FULL = 32'hffff_ffff;
  localparam logic [31:0] MSK_LOW16 = 32'h0000_ffff;
  localparam logic [31:0] MSK_BLD_CTRL = 32'h1f03_00ff;
  localparam logic [31:0] RST_VAL = 32'h0000_0000;
  localparam int BIT_FLIP = 31;
  localparam int BIT_SRC = 27;
  localparam int BIT_PTR_EN = 31;
  localparam int BIT_PTR_TOP = 27;
  localparam int BIT_PTR_LEFT = 11;
  localparam int BIT_VSHRINK = 31;
  localparam int BIT_HSHRINK = 15;
  localparam int BIT_ASEL = 28;
  localparam int BIT_KEY_EN = 3;
  localparam int BIT_PLANE_EN = 2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // Fetch request thresholds per level code
  localparam logic [3:0] LVL0 = 4'h1;
  localparam logic [3:0] LVL1 = 4'h3;
  localparam logic [3:0] LVL2 = 4'h7;
  localparam logic [3:0] LVL3 = 4'hb;
endpackage

/* File: verif/ocpr_regs_tb.sv */
// Self-checking bench for the overlay, pointer and blend register bank.
// Assumes a zero-wait AHB-Lite slave and registered decoded outputs.
`timescale 1ns/1ns
module ocpr_regs_tb;
  // Bench signals; the stimulus is driven from time zero, while rd and the design outputs are not
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic flip_done = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = ocpr_pkg::HSIZE_WORD;
  logic [3:0] empty = 4'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hready, hresp, src_o, vs_o, hs_o, show_o, psrc_o;
  logic ca_o, key_o, pen_o, req_o, flip_o;
  logic [11:0] vr_o, hr_o;
  logic [3:0] al_o;
  logic [1:0] fmt_o;
  logic [3:0] thr [4];
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  // Clock at 25 MHz
  initial begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  ocpr_regs u_dut (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .flip_done_i(flip_done), .blend_empty_i(empty),
    .ovl_src_host_o(src_o), .ovl_vshrink_o(vs_o), .ovl_hshrink_o(hs_o),
    .vertical_ratio_o(vr_o), .horizontal_ratio_o(hr_o),
    .pointer_overlay_show_o(show_o), .pointer_src_host_o(psrc_o),
    .blend_const_alpha_o(ca_o), .blend_alpha_o(al_o),
    .key_match_enable_o(key_o), .blend_plane_en_o(pen_o),
    .blend_format_o(fmt_o), .blend_fetch_req_o(req_o),
    .flip_pending_o(flip_o)
  );

  // Verdict and end of run, the only exit
  task automatic stop_test();
    $display("checked %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Case compare so an unknown never matches
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One AHB-Lite single transfer; read data taken at the data-phase edge
  task automatic xfer(input logic wr, input logic [19:0] ofs,
                      input logic [31:0] d);
    @(posedge sys_clk_i);
    hsel <= 1'b1;
    haddr <= {12'h0, ofs};
    htrans <= ocpr_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge sys_clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [19:0] ofs, input logic [31:0] exp,
                       input string what);
    xfer(1'b0, ofs, 32'h0);
    chk(what, exp, rd);
    chk("response", 32'h0, {31'h0, hresp});
  endtask

  // Reset value, writable bits, then clear back to zero
  task automatic rw(input logic [19:0] ofs, input logic [31:0] msk,
                    input string what);
    rdchk(ofs, ocpr_pkg::RST_VAL, what);
    xfer(1'b1, ofs, 32'hffff_ffff);
    rdchk(ofs, msk, what);
    xfer(1'b1, ofs, 32'h0);
    rdchk(ofs, 32'h0, what);
  endtask

  // Decoded outputs lag the register by one cycle
  task automatic settle();
    repeat (2) @(posedge sys_clk_i);
  endtask

  // Hang guard; the run needs well under a thousand cycles
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      $display("[ERR] run length expected done seen hang");
      stop_test();
    end
  end

  initial begin
    thr = '{ocpr_pkg::LVL0, ocpr_pkg::LVL1, ocpr_pkg::LVL2, ocpr_pkg::LVL3};
    repeat (16) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    // Reset values, writable masks, reserved bits
    rw(ocpr_pkg::OFS_OVL_STRIDE, ocpr_pkg::MSK_STRIDE, "stride");
    rw(ocpr_pkg::OFS_OVL_LAST, ocpr_pkg::MSK_ADDR, "last");
    rw(ocpr_pkg::OFS_OVL_TL, ocpr_pkg::MSK_LOC, "top left");
    rw(ocpr_pkg::OFS_OVL_BR, ocpr_pkg::MSK_LOC, "bottom right");
    rw(ocpr_pkg::OFS_OVL_SCALE, ocpr_pkg::MSK_SCALE, "scale");
    rw(ocpr_pkg::OFS_OVL_INIT, ocpr_pkg::MSK_INIT, "init scale");
    rw(ocpr_pkg::OFS_OVL_KEY, ocpr_pkg::MSK_FULL, "key");
    for (int i = 0; i < ocpr_pkg::PAL_WORDS; i++) begin
      rw(ocpr_pkg::OFS_OVL_PAL + 20'(4 * i), ocpr_pkg::MSK_FULL, "pal");
    end
    rw(ocpr_pkg::OFS_PTR_ADDR, ocpr_pkg::MSK_PTR_ADDR, "ptr addr");
    rw(ocpr_pkg::OFS_PTR_POS, ocpr_pkg::MSK_PTR_POS, "ptr pos");
    rw(ocpr_pkg::OFS_PTR_COL12, ocpr_pkg::MSK_FULL, "col12");
    rw(ocpr_pkg::OFS_PTR_COL3, ocpr_pkg::MSK_LOW16, "col3");
    rw(ocpr_pkg::OFS_BLD_CTRL, ocpr_pkg::MSK_BLD_CTRL, "ctrl");
    rw(ocpr_pkg::OFS_BLD_ADDR, ocpr_pkg::MSK_ADDR, "blend addr");
    $display("test register masks done");
    // Flip status set by a write, cleared by the pipe
    rdchk(ocpr_pkg::OFS_OVL_ADDR, ocpr_pkg::RST_VAL, "ovl addr");
    xfer(1'b1, ocpr_pkg::OFS_OVL_ADDR, 32'hffff_ffff);
    rdchk(ocpr_pkg::OFS_OVL_ADDR, 32'h8bff_fff0, "ovl addr");
    chk("flip out", 32'h1, {31'h0, flip_o});
    @(posedge sys_clk_i);
    flip_done <= 1'b1;
    @(posedge sys_clk_i);
    flip_done <= 1'b0;
    rdchk(ocpr_pkg::OFS_OVL_ADDR, ocpr_pkg::MSK_OVL_ADDR, "ovl addr");
    chk("flip out", 32'h0, {31'h0, flip_o});
    chk("ovl source", 32'h1, {31'h0, src_o});
    $display("test flip status done");
    // Shrink selects and ratios, both directions
    xfer(1'b1, ocpr_pkg::OFS_OVL_SCALE, 32'h8555_0aaa);
    settle();
    chk("scale out", {8'h2, 24'h555aaa}, {6'h0, vs_o, hs_o, vr_o, hr_o});
    xfer(1'b1, ocpr_pkg::OFS_OVL_SCALE, 32'h0123_8456);
    settle();
    chk("scale out", {8'h1, 24'h123456}, {6'h0, vs_o, hs_o, vr_o, hr_o});
    // Pointer enable and memory source
    xfer(1'b1, ocpr_pkg::OFS_PTR_ADDR, 32'h8800_0010);
    settle();
    chk("ptr out", 32'h3, {30'h0, show_o, psrc_o});
    xfer(1'b1, ocpr_pkg::OFS_PTR_ADDR, 32'h0000_0010);
    settle();
    chk("ptr out", 32'h0, {30'h0, show_o, psrc_o});
    $display("test scale and pointer done");
    // Every level code and format, request at threshold boundaries
    for (int l = 0; l < 4; l++) begin
      xfer(1'b1, ocpr_pkg::OFS_BLD_CTRL, {3'h0, 1'b1, 4'(l * 5), 6'h0,
           2'(l), 8'h0, 4'(l), 2'h3, 2'(l)});
      rdchk(ocpr_pkg::OFS_BLD_CTRL, {4'h1, 4'(l * 5), 6'h0, 2'(l), 8'h0,
            4'(l), 2'h3, 2'(l)}, "ctrl");
      chk("blend out", {23'h0, 1'b1, 4'(l * 5), 2'h3, 2'(l)},
          {23'h0, ca_o, al_o, key_o, pen_o, fmt_o});
      empty <= thr[l] - 4'h1;
      settle();
      chk("fetch req", 32'h0, {31'h0, req_o});
      empty <= thr[l];
      settle();
      chk("fetch req", 32'h1, {31'h0, req_o});
    end
    // Plane off: no request even with the fifo empty
    xfer(1'b1, ocpr_pkg::OFS_BLD_CTRL, 32'h0000_0008);
    empty <= 4'hf;
    settle();
    chk("blend out", 32'h8, {23'h0, ca_o, al_o, key_o, pen_o, fmt_o});
    chk("fetch req", 32'h0, {31'h0, req_o});
    $display("test blend control done");
    // Unmapped place and a byte-sized write are both dropped
    xfer(1'b1, 20'h800c4, 32'hffff_ffff);
    rdchk(20'h800c4, 32'h0, "unmapped");
    hsize <= 3'h0;
    xfer(1'b1, ocpr_pkg::OFS_OVL_KEY, 32'hffff_ffff);
    hsize <= ocpr_pkg::HSIZE_WORD;
    rdchk(ocpr_pkg::OFS_OVL_KEY, 32'h0, "key");
    $display("test refused accesses done");
    stop_test();
  end
endmodule
